// *** logic/hcr_pkg.sv ***
package hcr_pkg;
   // ************************************************************
   // Request type patterns, care masks, request codes
   // ************************************************************
   localparam logic [7:0]  TYPE_PORT_STATUS = 8'hA3;       // 10100011B
   localparam logic [7:0]  TYPE_SET_HUBDESC = 8'h20;       // 00100000B
   localparam logic [7:0]  TYPE_HUB_FEATURE = 8'h20;       // x0100000B
   localparam logic [7:0]  TYPE_PORT_FEAT   = 8'h23;       // x0100011B
   localparam logic [7:0]  CARE_ALL         = 8'hFF;       // Every bit compared
   localparam logic [7:0]  CARE_NO_MSB      = 8'h7F;       // Bit 7 is don't-care
   localparam logic [7:0]  REQ_GET_STATUS   = 8'h00;       // Get status code
   localparam logic [7:0]  REQ_CLR_FEATURE  = 8'h01;       // Clear feature code
   localparam logic [7:0]  REQ_SET_FEATURE  = 8'h03;       // Set feature code
   localparam logic [7:0]  REQ_SET_DESC     = 8'h07;       // Set descriptor code
   localparam logic [15:0] LEN_PORT_STATUS  = 16'h0004;    // Four bytes returned
   localparam logic [15:0] LEN_ZERO         = 16'h0000;    // No data stage
   // ************************************************************
   // Feature selectors
   // ************************************************************
   localparam logic [15:0] FSEL_CONNECTION  = 16'h0000;    // Connection
   localparam logic [15:0] FSEL_ENABLE      = 16'h0001;    // Enable
   localparam logic [15:0] FSEL_SUSPEND     = 16'h0002;    // Suspend
   localparam logic [15:0] FSEL_OVERCUR     = 16'h0003;    // Over-current
   localparam logic [15:0] FSEL_RESET       = 16'h0004;    // Reset
   localparam logic [15:0] FSEL_POWER       = 16'h0008;    // Power
   localparam logic [15:0] FSEL_LOWSPEED    = 16'h0009;    // Low speed
   localparam logic [15:0] FSEL_C_CONNECT   = 16'h0010;    // Connect change
   localparam logic [15:0] FSEL_C_ENABLE    = 16'h0011;    // Enable change
   localparam logic [15:0] FSEL_C_SUSPEND   = 16'h0012;    // Suspend change
   localparam logic [15:0] FSEL_C_OVERCUR   = 16'h0013;    // Over-current change
   localparam logic [15:0] FSEL_C_RESET     = 16'h0014;    // Reset change
   // ************************************************************
   // Status bit positions, counts
   // ************************************************************
   localparam int          ST_CONN  = 0;                   // Connect bit
   localparam int          ST_ENA   = 1;                   // Enable bit
   localparam int          ST_SUSP  = 2;                   // Suspend bit
   localparam int          ST_OVC   = 3;                   // Over-current bit
   localparam int          ST_RST   = 4;                   // Reset bit
   localparam int          ST_PWR   = 8;                   // Power bit
   localparam int          ST_LS    = 9;                   // Low-speed bit
   localparam int          NUM_PORTS = 4;                  // Downstream ports
   localparam logic [15:0] PWR_RESET = 16'h0000;           // Power off after reset
   localparam logic [7:0]  RESET_CYCLES = 8'hFA;           // Reset pulse, 250 cycles
endpackage

// *** logic/hcr_match.sv ***
`timescale 1ns/1ps
// ************************************************************
// Masked byte compare
// ************************************************************
module hcr_match
   import hcr_pkg::*;
(
   input  wire logic [7:0] value,      // Byte under test
   input  wire logic [7:0] pattern,    // Expected pattern
   input  wire logic [7:0] care,       // Ones mark compared bits
   output logic            hit         // Masked equality
);
   // Don't-care bits masked, the rest exact
   assign hit = ((value ^ pattern) & care) == 8'h00;
endmodule

// *** logic/hcr_decoder.sv ***
`timescale 1ns/1ps
module hcr_decoder
   import hcr_pkg::*;
#(
   parameter int NPORT = NUM_PORTS                    // Downstream port count
)(
   input  wire logic             clk,               // 25 MHz clock
   input  wire logic             nrst,              // Async reset, active low
   input  wire logic             ce,                // Clock enable
   input  wire logic             setup_valid,       // Setup packet strobe
   input  wire logic [7:0]       req_type,          // Request type byte
   input  wire logic [7:0]       req_code,          // Request code byte
   input  wire logic [15:0]      req_value,         // Value field
   input  wire logic [15:0]      req_index,         // Index field
   input  wire logic [15:0]      req_length,        // Length field
   input  wire logic [NPORT-1:0] dev_connect_pin,   // Device present, async
   input  wire logic [NPORT-1:0] dev_lowspeed_pin,  // Low-speed device, async
   input  wire logic [NPORT-1:0] overcur_pin,       // Over-current, async
   input  wire logic [NPORT-1:0] resume_done,       // Resume complete pulse
   output logic                  ack,               // Request accepted pulse
   output logic                  stall,             // Request stalled pulse
   output logic                  data_valid,        // Reply word strobe
   output logic [15:0]           data_word,         // Reply word
   output logic                  data_last,         // Last reply word
   output logic [NPORT-1:0]      port_enable,       // Port enabled
   output logic [NPORT-1:0]      port_suspend,      // Port suspended
   output logic [NPORT-1:0]      port_power,        // Port powered
   output logic [NPORT-1:0]      port_reset         // Reset signalling active
);
   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   logic [NPORT-1:0] conn_s1, conn_s2;             // Connect sync stages
   logic [NPORT-1:0] ls_s1,   ls_s2;               // Low-speed sync stages
   logic [NPORT-1:0] ovc_s1,  ovc_s2;              // Over-current sync stages
   logic [NPORT-1:0] conn_d,  ovc_d;               // Previous synced values
   // Two flops per pin before any logic reads it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conn_s1 <= '0;
         conn_s2 <= '0;
         ls_s1   <= '0;
         ls_s2   <= '0;
         ovc_s1  <= '0;
         ovc_s2  <= '0;
      end else if (ce) begin
         conn_s1 <= dev_connect_pin;
         conn_s2 <= conn_s1;
         ls_s1   <= dev_lowspeed_pin;
         ls_s2   <= ls_s1;
         ovc_s1  <= overcur_pin;
         ovc_s2  <= ovc_s1;
      end
   end
   // ************************************************************
   // Request decode
   // ************************************************************
   logic hit_gps, hit_shd, hit_shf, hit_spf, hit_cpf;   // Type matches
   hcr_match u_m_gps (.value(req_type), .pattern(TYPE_PORT_STATUS), .care(CARE_ALL),
                      .hit(hit_gps));
   hcr_match u_m_shd (.value(req_type), .pattern(TYPE_SET_HUBDESC), .care(CARE_ALL),
                      .hit(hit_shd));
   hcr_match u_m_shf (.value(req_type), .pattern(TYPE_HUB_FEATURE), .care(CARE_NO_MSB),
                      .hit(hit_shf));
   hcr_match u_m_spf (.value(req_type), .pattern(TYPE_PORT_FEAT), .care(CARE_NO_MSB),
                      .hit(hit_spf));
   assign hit_cpf = hit_spf;                        // Clear uses same type pattern

   logic                   port_ok;                 // Port 1..NPORT
   logic [1:0]             pidx;                    // Zero-based port
   logic                   is_gps, is_spf, is_cpf;  // Request classes
   logic                   feat_ok;                 // Feature allowed
   logic                   go_ack, go_stall;        // Decision
   // Port 0 and ports above the count have no port behind them
   assign port_ok = (req_index != 16'h0000) && (req_index <= 16'(NPORT));
   assign pidx    = 2'(req_index - 16'h0001);
   assign is_gps  = hit_gps && req_code == REQ_GET_STATUS && req_value == 16'h0000
                    && req_length == LEN_PORT_STATUS;
   assign is_spf  = hit_spf && req_code == REQ_SET_FEATURE
                    && req_length == LEN_ZERO;
   assign is_cpf  = hit_cpf && req_code == REQ_CLR_FEATURE && req_length == LEN_ZERO;

   // Set/clear acceptance per feature; connection and low speed never
   always_comb begin
      feat_ok = 1'b0;
      if (is_spf) begin
         case (req_value)
            FSEL_ENABLE, FSEL_SUSPEND, FSEL_RESET, FSEL_POWER: feat_ok = 1'b1;
            default: feat_ok = 1'b0;                       // Low speed refused
         endcase
      end else if (is_cpf) begin
         case (req_value)
            FSEL_ENABLE, FSEL_SUSPEND, FSEL_POWER, FSEL_OVERCUR,
            FSEL_C_CONNECT, FSEL_C_ENABLE, FSEL_C_SUSPEND,
            FSEL_C_OVERCUR, FSEL_C_RESET: feat_ok = 1'b1;
            default: feat_ok = 1'b0;
         endcase
      end
   end
   // Hub descriptor and hub feature writes stall first
   always_comb begin
      go_ack   = 1'b0;
      go_stall = 1'b0;
      if (hit_shd && req_code == REQ_SET_DESC) begin
         go_stall = 1'b1;
      end else if (hit_shf && req_code == REQ_SET_FEATURE) begin
         go_stall = 1'b1;
      end else if (is_gps) begin
         go_ack   = port_ok;
         go_stall = !port_ok;
      end else if (is_spf || is_cpf) begin
         go_ack   = port_ok && feat_ok;
         go_stall = !(port_ok && feat_ok);
      end else begin
         go_stall = 1'b1;                 // Nothing else handled here
      end
   end
   logic take;                                      // Accepted request edge
   logic busy_reg;                                  // Reply in progress
   assign take = ce && setup_valid && !busy_reg;
   // ************************************************************
   // Handshake outputs
   // ************************************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ack   <= 1'b0;
         stall <= 1'b0;
      end else if (ce) begin
         ack   <= setup_valid && !busy_reg && go_ack;
         stall <= setup_valid && !busy_reg && go_stall;
      end
   end
   // ************************************************************
   // Port state
   // ************************************************************
   logic [NPORT-1:0] c_conn, c_ena, c_susp, c_ovc, c_rst;  // Change flags
   logic [7:0]       rst_cnt [NPORT];               // Reset timers
   logic             do_set, do_clr;                // Accepted feature writes
   assign do_set = take && go_ack && is_spf;
   assign do_clr = take && go_ack && is_cpf;
   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_port
         logic sel;                                 // This port addressed
         logic rst_end;                             // Reset timer expiring
         assign sel     = (pidx == 2'(g));
         assign rst_end = port_reset[g] && rst_cnt[g] == 8'h01;
         // Control bits follow accepted writes; over-current cuts power
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               port_enable[g]  <= 1'b0;
               port_suspend[g] <= 1'b0;
               port_power[g]   <= PWR_RESET[g];
               port_reset[g]   <= 1'b0;
               rst_cnt[g]      <= 8'h00;
            end else if (ce) begin
               if (do_set && sel) begin
                  if (req_value == FSEL_ENABLE)  port_enable[g]  <= 1'b1;
                  if (req_value == FSEL_SUSPEND) port_suspend[g] <= 1'b1;
                  if (req_value == FSEL_POWER)   port_power[g]   <= 1'b1;
                  if (req_value == FSEL_RESET) begin
                     port_reset[g] <= 1'b1;
                     rst_cnt[g]    <= RESET_CYCLES;
                  end
               end else if (do_clr && sel) begin
                  if (req_value == FSEL_ENABLE)  port_enable[g]  <= 1'b0;
                  if (req_value == FSEL_SUSPEND) port_suspend[g] <= 1'b0;
                  if (req_value == FSEL_POWER)   port_power[g]   <= 1'b0;
               end
               if (rst_end) begin
                  port_reset[g]  <= 1'b0;
                  port_enable[g] <= 1'b1;           // Reset completes enabled
               end else if (port_reset[g]) begin
                  rst_cnt[g] <= rst_cnt[g] - 8'h01;
               end
               if (resume_done[g]) port_suspend[g] <= 1'b0;
               if (ovc_s2[g]) begin
                  port_power[g]  <= 1'b0;
                  port_enable[g] <= 1'b0;
               end
            end
         end
         // Change flags: hardware set wins over host clear
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               c_conn[g] <= 1'b0;
               c_ena[g]  <= 1'b0;
               c_susp[g] <= 1'b0;
               c_ovc[g]  <= 1'b0;
               c_rst[g]  <= 1'b0;
            end else if (ce) begin
               if (do_clr && sel && req_value == FSEL_C_CONNECT) c_conn[g] <= 1'b0;
               if (do_clr && sel && req_value == FSEL_C_ENABLE)  c_ena[g]  <= 1'b0;
               if (do_clr && sel && req_value == FSEL_C_SUSPEND) c_susp[g] <= 1'b0;
               if (do_clr && sel && (req_value == FSEL_C_OVERCUR
                                     || req_value == FSEL_OVERCUR)) c_ovc[g] <= 1'b0;
               if (do_clr && sel && req_value == FSEL_C_RESET)   c_rst[g]  <= 1'b0;
               if (conn_s2[g] != conn_d[g]) c_conn[g] <= 1'b1;
               if (ovc_s2[g] && port_enable[g]) c_ena[g] <= 1'b1;
               if (resume_done[g] && port_suspend[g]) c_susp[g] <= 1'b1;
               if (ovc_s2[g] != ovc_d[g]) c_ovc[g] <= 1'b1;
               if (rst_end) c_rst[g] <= 1'b1;
            end
         end
      end
   endgenerate
   // Edge history for change detection
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         conn_d <= '0;
         ovc_d  <= '0;
      end else if (ce) begin
         conn_d <= conn_s2;
         ovc_d  <= ovc_s2;
      end
   end
   // ************************************************************
   // Status reply: status word then change word
   // ************************************************************
   logic [15:0] chg_hold;                           // Change word for second beat
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_reg   <= 1'b0;
         data_valid <= 1'b0;
         data_last  <= 1'b0;
         data_word  <= 16'h0000;
         chg_hold   <= 16'h0000;
      end else if (ce) begin
         data_valid <= 1'b0;
         data_last  <= 1'b0;
         if (take && go_ack && is_gps) begin
            busy_reg   <= 1'b1;
            data_valid <= 1'b1;
            data_word  <= 16'h0000;
            data_word[ST_CONN] <= conn_s2[pidx];
            data_word[ST_ENA]  <= port_enable[pidx];
            data_word[ST_SUSP] <= port_suspend[pidx];
            data_word[ST_OVC]  <= ovc_s2[pidx];
            data_word[ST_RST]  <= port_reset[pidx];
            data_word[ST_PWR]  <= port_power[pidx];
            data_word[ST_LS]   <= ls_s2[pidx];
            chg_hold <= {11'h000, c_rst[pidx], c_ovc[pidx], c_susp[pidx],
                         c_ena[pidx], c_conn[pidx]};
         end else if (busy_reg) begin
            busy_reg   <= 1'b0;
            data_valid <= 1'b1;
            data_last  <= 1'b1;
            data_word  <= chg_hold;
         end
      end
   end
   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_beat_status;
      data_valid && !data_last;
   endsequence
   sequence s_beat_change;
      data_valid && data_last;
   endsequence
   property p_status_order;
      @(posedge clk) disable iff (!nrst) (s_beat_status ##0 ce) |=> s_beat_change;
   endproperty
   a_status_order: assert property (p_status_order) else $error("change word missing");
   property p_port0_stall;
      @(posedge clk) disable iff (!nrst)
         (ce && setup_valid && !busy_reg && req_index == 16'h0000 && is_gps) |=> stall;
   endproperty
   a_port0_stall: assert property (p_port0_stall) else $error("port zero not stalled");
   property p_hubdesc;
      @(posedge clk) disable iff (!nrst)
         (ce && setup_valid && !busy_reg && req_type == 8'h20 && req_code == 8'h07) |=> stall;
   endproperty
   a_hubdesc: assert property (p_hubdesc) else $error("hub descriptor not stalled");
   property p_hubfeat;
      @(posedge clk) disable iff (!nrst)
         (ce && setup_valid && !busy_reg && req_type[6:0] == 7'h20 && req_code == 8'h03)
         |=> stall && !ack;
   endproperty
   a_hubfeat: assert property (p_hubfeat) else $error("hub feature not stalled");
   property p_lowspeed;
      @(posedge clk) disable iff (!nrst)
         (ce && setup_valid && !busy_reg && is_spf && req_value == 16'h0009) |=> stall;
   endproperty
   a_lowspeed: assert property (p_lowspeed) else $error("low speed set accepted");
   property p_exclusive;
      @(posedge clk) disable iff (!nrst) !(ack && stall);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("ack and stall together");
   property p_power_set;
      @(posedge clk) disable iff (!nrst)
         (do_set && req_value == 16'h0008 && !ovc_s2[pidx]) |=> port_power[$past(pidx)];
   endproperty
   a_power_set: assert property (p_power_set) else $error("power set not applied");
   property p_gps_reply;
      @(posedge clk) disable iff (!nrst)
         (take && go_ack && is_gps) |=> data_valid && ack;
   endproperty
   a_gps_reply: assert property (p_gps_reply) else $error("no status reply");
endmodule

// *** dv/hcr_host_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Upstream host issuing setup packets on the control pipe
// ************************************************************
module hcr_host_model (
   input  wire logic        clk,          // Bench clock
   output logic             setup_valid,  // Setup strobe
   output logic [7:0]       req_type,     // Request type
   output logic [7:0]       req_code,     // Request code
   output logic [15:0]      req_value,    // Value field
   output logic [15:0]      req_index,    // Index field
   output logic [15:0]      req_length,   // Length field
   input  wire logic        ack,          // Accept pulse
   input  wire logic        stall,        // Stall pulse
   input  wire logic        data_valid,   // Reply strobe
   input  wire logic [15:0] data_word,    // Reply word
   input  wire logic        data_last     // Last reply word
);
   // Idle bus at time zero
   initial begin
      setup_valid = 1'b0;
      {req_type, req_code, req_value, req_index, req_length} = '0;
   end
   // One packet; fields inverted after the take so stale values never pass
   task automatic xfer(input logic [7:0] t, c, input logic [15:0] v, i, l,
                       output logic [1:0] resp, output logic [3:0] dv,
                       output logic [15:0] w0, w1);
      @(posedge clk);
      setup_valid <= 1'b1;
      {req_type, req_code, req_value, req_index, req_length} <= {t, c, v, i, l};
      @(posedge clk);
      setup_valid <= 1'b0;
      {req_type, req_code, req_value, req_index, req_length} <= ~{t, c, v, i, l};
      @(posedge clk);
      resp = {ack, stall};
      dv[3:2] = {data_valid, data_last};
      w0 = data_word;
      @(posedge clk);
      dv[1:0] = {data_valid, data_last};
      w1 = data_word;
   endtask
endmodule

// *** dv/hub_class_request_decoder_bench.sv ***
`timescale 1ns/1ps
module hub_class_request_decoder_bench;
   import hcr_pkg::*;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam logic [5:0] ACK = 6'h20;     // Accept, no data
   localparam logic [5:0] STL = 6'h10;     // Stall, no data
   localparam logic [5:0] GPS = 6'h2B;     // Accept, two words
   logic              clk, nrst, ce;       // Clock, reset, enable
   logic              sv, ack, stall;      // Setup strobe, answers
   logic [7:0]        rt, rc;              // Type, code
   logic [15:0]       rv, ri, rl, dw;      // Fields, reply word
   logic              dvl, dlast;          // Reply strobes
   logic [3:0]        conn, ls, ovc, rdn;  // Port pins
   logic [3:0]        p_en, p_su, p_pw, p_rs; // Port outputs
   logic [1:0]        resp;                // Sampled answer
   logic [3:0]        dv;                  // Sampled reply strobes
   logic [15:0]       w0, w1;              // Sampled words
   int                bad_count, total_checks; // Tallies
   logic [15:0] sel_tab [10] = '{16'h00, 16'h01, 16'h02, 16'h03, 16'h04, 16'h08, 16'h09,
                                 16'h11, 16'h12, 16'h14}; // Selectors under test
   // Clock, 40 ns period
   always #20 clk = ~clk;
   hcr_host_model host_u (.clk(clk), .setup_valid(sv), .req_type(rt), .req_code(rc),
      .req_value(rv), .req_index(ri), .req_length(rl), .ack(ack), .stall(stall),
      .data_valid(dvl), .data_word(dw), .data_last(dlast));
   hcr_decoder #(.NPORT(4)) dut_u (.clk(clk), .nrst(nrst), .ce(ce), .setup_valid(sv),
      .req_type(rt), .req_code(rc), .req_value(rv), .req_index(ri), .req_length(rl),
      .dev_connect_pin(conn), .dev_lowspeed_pin(ls), .overcur_pin(ovc),
      .resume_done(rdn), .ack(ack), .stall(stall), .data_valid(dvl), .data_word(dw),
      .data_last(dlast), .port_enable(p_en), .port_suspend(p_su), .port_power(p_pw),
      .port_reset(p_rs));
   // ************************************************************
   // Compare and request helpers
   // ************************************************************
   task automatic chk_word(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [5:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Issue one packet and judge answer plus reply strobes together
   task automatic req(input logic [7:0] t, c, input logic [15:0] v, i, l,
                      input logic [5:0] exp);
      host_u.xfer(t, c, v, i, l, resp, dv, w0, w1);
      chk_resp({resp, dv}, exp);
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_status_and_hub();
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h1, LEN_PORT_STATUS, GPS);
      chk_word(w0, 16'h0000);
      chk_word(w1, 16'h0000);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h1, 16'h1, LEN_PORT_STATUS, STL);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h0, LEN_PORT_STATUS, STL);
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_POWER, 16'h5, LEN_ZERO, STL);
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_POWER, 16'h1, 16'h1, STL);
      req(TYPE_SET_HUBDESC, REQ_SET_DESC, 16'h1234, 16'h5678, 16'h9ABC, STL);
      req(8'hA0, REQ_SET_FEATURE, 16'hFFFF, 16'h1, 16'h0, STL);
      req(TYPE_HUB_FEATURE, REQ_SET_FEATURE, 16'h0, 16'h0, 16'h0, STL);
   endtask
   // Set and clear acceptance per selector on port 3, bit 7 of type toggled on the set requests only
   task automatic t_tables();
      logic [9:0] set_ok;
      logic [9:0] clr_ok;
      set_ok = 10'b0000110110;
      clr_ok = 10'b1110101110;
      for (int k = 0; k < 10; k++) begin
         req(k[0] ? 8'hA3 : TYPE_PORT_FEAT, REQ_SET_FEATURE, sel_tab[k], 16'h3, LEN_ZERO,
             set_ok[k] ? ACK : STL);
      end
      for (int k = 0; k < 10; k++) begin
         req(TYPE_PORT_FEAT, REQ_CLR_FEATURE, sel_tab[k], 16'h3, LEN_ZERO,
             clr_ok[k] ? ACK : STL);
      end
   endtask
   // Accepted settings show on port 1 outputs and in its status
   task automatic t_effects();
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_POWER, 16'h1, LEN_ZERO, ACK);
      chk_word({15'h0, p_pw[0]}, 16'h1);
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_ENABLE, 16'h1, LEN_ZERO, ACK);
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_SUSPEND, 16'h1, LEN_ZERO, ACK);
      chk_word({14'h0, p_su[0], p_en[0]}, 16'h3);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h1, LEN_PORT_STATUS, GPS);
      chk_word(w0 & 16'h0106, 16'h0106);
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_RESET, 16'h1, LEN_ZERO, ACK);
      chk_word({15'h0, p_rs[0]}, 16'h1);
      repeat (int'(RESET_CYCLES) + 10) @(posedge clk);
      chk_word({14'h0, p_en[0], p_rs[0]}, 16'h2);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h1, LEN_PORT_STATUS, GPS);
      chk_word(w1 & 16'h0010, 16'h0010);
      req(TYPE_PORT_FEAT, REQ_CLR_FEATURE, FSEL_C_RESET, 16'h1, LEN_ZERO, ACK);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h1, LEN_PORT_STATUS, GPS);
      chk_word(w1 & 16'h0010, 16'h0000);
      req(TYPE_PORT_FEAT, REQ_CLR_FEATURE, FSEL_POWER, 16'h1, LEN_ZERO, ACK);
      chk_word({15'h0, p_pw[0]}, 16'h0);
   endtask
   // Low speed comes from the attached device only, on port 4
   task automatic t_lowspeed();
      @(posedge clk);
      conn <= 4'h8;
      ls <= 4'h8;
      repeat (6) @(posedge clk);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h4, LEN_PORT_STATUS, GPS);
      chk_word(w0 & 16'h0201, 16'h0201);
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_LOWSPEED, 16'h4, LEN_ZERO, STL);
   endtask
   // Over-current on port 2, resume on port 1, a request while frozen
   task automatic t_pins_and_freeze();
      req(TYPE_PORT_FEAT, REQ_SET_FEATURE, FSEL_POWER, 16'h2, LEN_ZERO, ACK);
      ovc <= 4'h2;
      repeat (6) @(posedge clk);
      chk_word({15'h0, p_pw[1]}, 16'h0);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h2, LEN_PORT_STATUS, GPS);
      chk_word(w0 & 16'h0108, 16'h0008);
      chk_word(w1 & 16'h0008, 16'h0008);
      ovc <= 4'h0;
      repeat (6) @(posedge clk);
      req(TYPE_PORT_FEAT, REQ_CLR_FEATURE, FSEL_OVERCUR, 16'h2, LEN_ZERO, ACK);
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h2, LEN_PORT_STATUS, GPS);
      chk_word(w1 & 16'h0008, 16'h0000);
      // Resume pulse ends suspend and raises its change flag
      rdn <= 4'h1;
      @(posedge clk);
      rdn <= 4'h0;
      req(TYPE_PORT_STATUS, REQ_GET_STATUS, 16'h0, 16'h1, LEN_PORT_STATUS, GPS);
      chk_word({14'h0, w0[2], w1[2]}, 16'h1);
      // Frozen block ignores the strobe, then answers once running again
      ce <= 1'b0;
      req(TYPE_SET_HUBDESC, REQ_SET_DESC, 16'h0, 16'h0, 16'h0, 6'h00);
      ce <= 1'b1;
      req(TYPE_SET_HUBDESC, REQ_SET_DESC, 16'h0, 16'h0, 16'h0, STL);
   endtask
   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      ce = 1'b1;
      {conn, ls, ovc, rdn} = '0;
      bad_count = 0;
      total_checks = 0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      t_status_and_hub();
      t_tables();
      t_effects();
      t_lowspeed();
      t_pins_and_freeze();
      report_and_stop();
   end
   // Whole run needs under two thousand cycles
   initial begin
      #(40 * 30000);
      bad_count++;
      report_and_stop();
   end
endmodule
